/* rtl/host_interrupt_output_control.sv */
`timescale 1ns/10ps
`include "irq_out_defines.svh"
module host_interrupt_output_control #(
   parameter logic [15:0] CHIP_ID = `CHIP_ID_DEFAULT // arbitrary value
) (
   input wire logic clk, // 25 MHz clock
   input wire logic reset_n, // hardware reset, synchronous, active low
   input wire logic soft_reset, // software reset pulse
   input wire logic [7:0] addr, // byte offset
   input wire logic [31:0] wdata, // write data
   input wire logic wr_en, // write strobe, one cycle
   input wire logic rd_en, // read strobe, one cycle
   output logic [31:0] rdata, // read data, registered
   input wire logic [31:0] event_set, // interrupt source pulses
   output logic irq_out, // pin output level
   output logic irq_oe // pin output enable
);
   logic [31:0] status_r;
   logic [31:0] enable_r;
   logic [31:0] fifo_level_r;
   logic [7:0] holdoff_interval_r;
   logic out_en_r;
   logic intr_output_polarity_r;
   logic push_pull_r;
   logic [7:0] steps_r;
   irq_out_pkg::hold_state_e state_r;
   logic tick;
   logic master;
   logic master_gated;
   logic pin_asserted;
   logic pin_asserted_r;
   logic wr_cfg;
   logic restart;
   logic interval_zero;
   logic wr_status;
   logic zero_write;
   logic holding;
   logic held_pending;
   logic power_pending;
   logic pin_fell;
   logic step_run;
   logic [31:0] held_mask;
   logic [31:0] cfg_word;

   // every source except the power event obeys the hold-off
   for (genvar b = 0; b < 32; b++) begin : g_held_mask
      assign held_mask[b] = (b != `BIT_POWER_EVENT);
   end

   assign wr_cfg = wr_en && (addr == `OFS_IRQ_CONFIG);
   assign wr_status = wr_en && (addr == `OFS_INT_STATUS);
   assign restart = wr_cfg && wdata[`BIT_RESTART];
   assign zero_write = wr_cfg && (wdata[`HOLDOFF_HI:`HOLDOFF_LO] == 8'h00);
   assign interval_zero = (holdoff_interval_r == 8'h00);
   assign holding = (state_r == irq_out_pkg::HOLD_RUN);

   // master line, ungated by output enable or hold-off
   assign master = |(status_r & enable_r);
   assign held_pending = |(status_r & enable_r & held_mask);
   // power event passes even during an interval
   assign power_pending = status_r[`BIT_POWER_EVENT] && enable_r[`BIT_POWER_EVENT];
   assign master_gated = (held_pending && !holding) || power_pending;
   assign pin_asserted = out_en_r && master_gated;
   assign pin_fell = pin_asserted_r && !pin_asserted;
   // tick counter held clear in the restart cycle, so the fresh interval runs full length
   assign step_run = holding && !restart;

   always_ff @(posedge clk) begin
      if (!reset_n || soft_reset) begin
         status_r <= 32'h00000000;
      end else begin
         // set wins over write-one-to-clear
         if (wr_status) begin
            status_r <= (status_r & ~wdata) | event_set;
         end else begin
            status_r <= status_r | event_set;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || soft_reset) begin
         enable_r <= 32'h00000000;
         fifo_level_r <= `FIFO_LEVEL_RESET;
      end else if (wr_en && addr == `OFS_INT_ENABLE) begin
         enable_r <= wdata;
      end else if (wr_en && addr == `OFS_FIFO_LEVEL) begin
         fifo_level_r <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || soft_reset) begin
         holdoff_interval_r <= 8'h00;
         out_en_r <= 1'b0;
      end else if (wr_cfg) begin
         holdoff_interval_r <= wdata[`HOLDOFF_HI:`HOLDOFF_LO];
         out_en_r <= wdata[`BIT_OUT_EN];
      end
   end

   // soft reset deliberately absent: these bits survive it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         intr_output_polarity_r <= 1'b0;
         push_pull_r <= 1'b0;
      end else if (wr_cfg) begin
         intr_output_polarity_r <= wdata[`BIT_POLARITY];
         push_pull_r <= wdata[`BIT_PUSH_PULL];
      end
   end

   // resets to the deasserted level, so no false fall follows a reset
   always_ff @(posedge clk) begin
      if (!reset_n || soft_reset) begin
         pin_asserted_r <= 1'b0;
      end else begin
         pin_asserted_r <= pin_asserted;
      end
   end

   step_tick u_tick (
      .clk(clk),
      .reset_n(reset_n),
      .run(step_run),
      .tick(tick)
   );

   // hold-off interval sequencer
   always_ff @(posedge clk) begin
      if (!reset_n || soft_reset) begin
         state_r <= irq_out_pkg::HOLD_IDLE;
         steps_r <= 8'h00;
      end else if (zero_write) begin
         // a zero field cancels even a restart in the same write
         state_r <= irq_out_pkg::HOLD_IDLE;
         steps_r <= 8'h00;
      end else if (restart) begin
         state_r <= irq_out_pkg::HOLD_RUN;
         steps_r <= 8'h00;
      end else begin
         unique case (state_r)
            irq_out_pkg::HOLD_IDLE: begin
               // falling pin starts an interval with current field
               if (pin_fell && !interval_zero) begin
                  state_r <= irq_out_pkg::HOLD_RUN;
                  steps_r <= 8'h00;
               end
            end
            irq_out_pkg::HOLD_RUN: begin
               if (tick) begin
                  if (steps_r + 8'h01 >= holdoff_interval_r) begin
                     state_r <= irq_out_pkg::HOLD_IDLE;
                     steps_r <= 8'h00;
                  end else begin
                     steps_r <= steps_r + 8'h01;
                  end
               end
            end
         endcase
      end
   end

   // pin flops keep decode glitches off a wired-or line, at one cycle of latency
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_oe <= 1'b0;
         irq_out <= 1'b0;
      end else if (push_pull_r) begin
         irq_oe <= 1'b1;
         irq_out <= pin_asserted ? intr_output_polarity_r : !intr_output_polarity_r;
      end else begin
         // open drain: pull low when asserted, release otherwise
         irq_oe <= pin_asserted;
         irq_out <= 1'b0;
      end
   end

   // restart bit reads back zero since it clears itself
   always_comb begin
      cfg_word = 32'h00000000;
      cfg_word[`HOLDOFF_HI:`HOLDOFF_LO] = holdoff_interval_r;
      cfg_word[`BIT_ACTIVE] = holding;
      cfg_word[`BIT_MASTER] = master;
      cfg_word[`BIT_OUT_EN] = out_en_r;
      cfg_word[`BIT_POLARITY] = intr_output_polarity_r;
      cfg_word[`BIT_PUSH_PULL] = push_pull_r;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= 32'h00000000;
      end else if (rd_en) begin
         unique case (addr)
            `OFS_CHIP_IDENTITY_REVISION: rdata <= {CHIP_ID, `REVISION_VALUE};
            `OFS_IRQ_CONFIG: rdata <= cfg_word;
            `OFS_INT_STATUS: rdata <= status_r;
            `OFS_INT_ENABLE: rdata <= enable_r;
            `OFS_BYTE_TEST: rdata <= `BYTE_TEST_VALUE;
            `OFS_FIFO_LEVEL: rdata <= fifo_level_r;
            // reserved and unmapped offsets read as zero
            default: rdata <= 32'h00000000;
         endcase
      end
   end
endmodule

/* rtl/irq_out_defines.svh */
`ifndef IRQ_OUT_DEFINES_SVH
`define IRQ_OUT_DEFINES_SVH
`define OFS_CHIP_IDENTITY_REVISION 8'h50
`define OFS_IRQ_CONFIG 8'h54
`define OFS_INT_STATUS 8'h58
`define OFS_INT_ENABLE 8'h5c
`define OFS_BYTE_TEST 8'h64
`define OFS_FIFO_LEVEL 8'h68
`define FIFO_LEVEL_RESET 32'h48000000
`define BYTE_TEST_VALUE 32'h87654321
`define REVISION_VALUE 16'h0000
`define CHIP_ID_DEFAULT 16'h5a5a
`define HOLDOFF_HI 31
`define HOLDOFF_LO 24
`define BIT_RESTART 14
`define BIT_ACTIVE 13
`define BIT_MASTER 12
`define BIT_OUT_EN 8
`define BIT_POLARITY 4
`define BIT_PUSH_PULL 0
`define BIT_POWER_EVENT 17
`define CLK_NS 40
`define STEP_NS 10000
`define STEP_CYCLES ((`STEP_NS) / (`CLK_NS))
`endif

/* rtl/irq_out_pkg.sv */
package irq_out_pkg;
   typedef enum logic [0:0] {
      HOLD_IDLE,
      HOLD_RUN
   } hold_state_e;
endpackage

/* rtl/step_tick.sv */
`timescale 1ns/10ps
`include "irq_out_defines.svh"
// emits one pulse every ten microseconds while running
module step_tick (
   input wire logic clk, // 25 MHz clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic run, // count while high, clear otherwise
   output logic tick // one-cycle pulse per step
);
   logic [8:0] cnt_r;
   always_ff @(posedge clk) begin
      if (!reset_n || !run) begin
         cnt_r <= 9'h000;
      end else if (cnt_r == 9'(`STEP_CYCLES - 1)) begin
         cnt_r <= 9'h000;
      end else begin
         cnt_r <= cnt_r + 9'h001;
      end
   end
   assign tick = run && (cnt_r == 9'(`STEP_CYCLES - 1));
endmodule

/* verif/host_cpu_model.sv */
`timescale 1ns/10ps
module host_cpu_model (
   input wire logic clk, // clock
   output logic [7:0] addr = 8'h00, // offset
   output logic [31:0] wdata = 32'h00000000, // data
   output logic wr_en = 1'b0, // write
   output logic rd_en = 1'b0 // read
);
   logic [31:0] exp_q[$];
   // reserved offsets never written; stale data inverted
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      {addr, wdata, wr_en} = {a, d, 1'b1};
      @(negedge clk);
      {wdata, wr_en} = {~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(negedge clk);
      {addr, rd_en} = {a, 1'b1};
      exp_q.push_back(e);
      @(negedge clk);
      rd_en = 1'b0;
   endtask
endmodule

/* verif/host_irq_properties.sv */
`timescale 1ns/10ps
module irq_checker (
   input wire logic clk, // clock
   input wire logic reset_n, // reset
   input wire logic soft_reset, // soft reset
   input wire logic [7:0] addr, // offset
   input wire logic [31:0] wdata, // data in
   input wire logic wr_en, // write
   input wire logic rd_en, // read
   input wire logic [31:0] rdata, // data out
   input wire logic [31:0] event_set, // sources
   input wire logic irq_out, // pin
   input wire logic irq_oe // pin enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_cw; wr_en && addr == 8'h54 && !soft_reset; endsequence
   sequence s_cr; rd_en && addr == 8'h54 && !wr_en && !soft_reset; endsequence
   property p_byte; rd_en && addr == 8'h64 |=> rdata == 32'h87654321; endproperty
   a_byte: assert property (p_byte) else $error("byte test read");
   property p_rev; rd_en && addr == 8'h50 |=> rdata[15:0] == 16'h0000; endproperty
   a_rev: assert property (p_rev) else $error("revision read");
   property p_od; irq_out |-> irq_oe; endproperty
   a_od: assert property (p_od) else $error("undriven high");
   property p_rst; $rose(reset_n) |-> !irq_oe; endproperty
   a_rst: assert property (p_rst) else $error("pin driven at reset");
   property p_off;
      s_cw ##0 (!wdata[8] && wdata[0]) ##1 !wr_en |=> irq_oe && irq_out == !$past(wdata[4], 2);
   endproperty
   a_off: assert property (p_off) else $error("idle level");
   property p_odoff; s_cw ##0 (!wdata[8] && !wdata[0]) ##1 !wr_en |=> !irq_oe; endproperty
   a_odoff: assert property (p_odoff) else $error("open drain idle");
   property p_back; s_cw ##1 !wr_en ##1 s_cr |=> rdata[31:24] == $past(wdata[31:24], 3); endproperty
   a_back: assert property (p_back) else $error("interval readback");
   property p_soft; s_cw ##0 wdata[0] ##1 (soft_reset && !wr_en) |=> ##1 irq_oe; endproperty
   a_soft: assert property (p_soft) else $error("buffer type lost");
endmodule
bind host_interrupt_output_control irq_checker u_chk (.*);

/* verif/test_host_interrupt_output_control.sv */
`timescale 1ns/10ps
module test_host_interrupt_output_control;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic soft_reset = 1'b0;
   logic [31:0] event_set = 32'h00000000;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic wr_en, rd_en, irq_out, irq_oe, rd_seen;
   int failures = 0;
   int cmp_count = 0;
   always #20 clk = ~clk;
   host_cpu_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en));
   // chip code 3c21h is arbitrary
   host_interrupt_output_control #(.CHIP_ID(16'h3c21)) DUT (.clk(clk), .reset_n(reset_n),
      .soft_reset(soft_reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .event_set(event_set), .irq_out(irq_out), .irq_oe(irq_oe));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic pin(input logic [1:0] x);
      @(negedge clk);
      chk("pin", {30'h0, x}, {30'h0, irq_oe, irq_out});
   endtask
   task automatic ev(input int b);
      @(negedge clk);
      event_set[b] = 1'b1;
      @(negedge clk);
      event_set[b] = 1'b0;
   endtask
   task automatic test_done;
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) rd_seen <= rd_en;
   always @(negedge clk) if (rd_seen === 1'b1) chk("rdata", host.exp_q.pop_front(), rdata);
   initial begin
      #400000;
      failures++;
      test_done;
   end
   initial begin
      void'($urandom(32'h994ee68e));
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      pin(2'b00);
      host.rd(8'h50, 32'h3c210000);
      host.wr(8'h64, $urandom());
      host.rd(8'h64, 32'h87654321);
      host.wr(8'h5c, 32'h00020200);
      host.rd(8'h5c, 32'h00020200);
      for (int i = 0; i < 4; i++) begin
         host.wr(8'h54, {23'h0, 1'b1, 3'h0, i[1], 3'h0, i[0]});
         ev(9);
         pin(i[0] ? {1'b1, i[1]} : 2'b10);
         host.wr(8'h54, {27'h0, i[1], 3'h0, i[0]});
         pin(i[0] ? {1'b1, ~i[1]} : 2'b00);
         host.rd(8'h54, {19'h0, 1'b1, 7'h0, i[1], 3'h0, i[0]});
         host.rd(8'h58, 32'h00000200);
         host.wr(8'h58, 32'h00000200);
      end
      host.wr(8'h54, 32'h02000111);
      host.rd(8'h54, 32'h02000111);
      ev(3);
      pin(2'b10);
      ev(9);
      pin(2'b11);
      host.wr(8'h58, 32'h00000200);
      ev(9);
      pin(2'b10);
      host.rd(8'h54, 32'h02003111);
      ev(17);
      pin(2'b11);
      host.wr(8'h58, 32'h00020000);
      repeat (470) @(negedge clk);
      pin(2'b10);
      repeat (60) @(negedge clk);
      pin(2'b11);
      host.wr(8'h54, 32'h02004111);
      pin(2'b10);
      host.wr(8'h54, 32'h00000111);
      pin(2'b11);
      host.wr(8'h54, 32'h00000111);
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      host.rd(8'h54, 32'h00000011);
      repeat (2) @(negedge clk);
      test_done;
   end
endmodule
